// >>> pec_pkg.sv
// constants and carrier types for the path error counters
package pec_pkg;
    localparam logic [7:0] ADDR_MASTER = 8'h00;
    localparam logic [7:0] ADDR_PARITY_LOW = 8'h38;
    localparam logic [7:0] ADDR_PARITY_HIGH = 8'h39;
    localparam logic [7:0] ADDR_FAR_END_LOW = 8'h3a;
    localparam logic [7:0] ADDR_FAR_END_HIGH = 8'h3b;
    localparam logic [7:0] ADDR_ACCUM_CONTROL = 8'h3d;
    localparam int BLOCK_MODE_BIT = 5;
    localparam logic [7:0] ACCUM_CONTROL_RESET = 8'h00;
    localparam logic [7:0] ACCUM_CONTROL_MASK = 8'h20;
    localparam logic [3:0] MAX_PARITY_BITS = 4'h8;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    typedef struct packed {
        logic valid;
        logic [3:0] amount;
    } pec_event_type;

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic [7:0] addr;
        logic [7:0] data;
    } pec_bus_type;
endpackage : pec_pkg

// >>> pec_accum.sv
// saturating 16-bit error accumulator with poll-to-holding transfer
`timescale 1ns/1ns
module pec_accum (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // events and poll
    input wire pec_pkg::pec_event_type event_in,
    input wire logic poll,
    // holding register
    output logic [15:0] hold_q
);
    logic [15:0] acc_q;
    logic [15:0] acc_d;
    logic [16:0] sum;

    always_comb begin
        sum = {1'b0, acc_q} + {13'h0000, event_in.amount};
        if (poll) begin
            // coincident event opens the new period
            acc_d = event_in.valid ? {12'h000, event_in.amount}
                                   : pec_pkg::COUNT_RESET;
        end else if (event_in.valid) begin
            acc_d = sum[16] ? pec_pkg::COUNT_MAX : sum[15:0];
        end else begin
            acc_d = acc_q;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            acc_q <= pec_pkg::COUNT_RESET;
        end else begin
            acc_q <= acc_d;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            hold_q <= pec_pkg::COUNT_RESET;
        end else if (poll) begin
            hold_q <= acc_q;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    a_hold_takes_count: assert property (
        poll |=> hold_q == $past(acc_q))
        else $error("holding register missed accumulated count");
    a_restart_keeps_event: assert property (
        poll |=> acc_q == ($past(event_in.valid)
                  ? {12'h000, $past(event_in.amount)} : 16'h0000))
        else $error("accumulator restart lost coincident event");
    a_count_saturates: assert property (
        acc_q == 16'hffff && !poll |=> acc_q == 16'hffff)
        else $error("accumulator wrapped past maximum");
    a_hold_stable: assert property (
        !poll |=> $stable(hold_q))
        else $error("holding register changed without poll");
    c_poll_with_event: cover property (poll && event_in.valid);
    c_saturated: cover property (acc_q == 16'hffff);
endmodule : pec_accum

// >>> pec_path_error_counters.sv
// receive path parity and far-end block error counters with register port
`timescale 1ns/1ns
module pec_path_error_counters (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // microprocessor port pins
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    // overhead extraction events
    input wire logic spe_done,
    input wire logic [3:0] parity_bits,
    input wire logic g1_done,
    input wire logic [3:0] far_end_value,
    // poll strobe to other receive counters
    output logic poll_all
);
    pec_pkg::pec_bus_type bus_s1_q;
    pec_pkg::pec_bus_type bus_s2_q;
    pec_pkg::pec_bus_type bus_s3_q;
    logic [7:0] control_q;
    logic [7:0] data_out_q;
    logic data_oe_q;
    logic poll_all_q;
    logic write_done;
    logic path_poll;
    logic [15:0] parity_hold;
    logic [15:0] far_end_hold;
    logic [3:0] parity_clip;
    pec_pkg::pec_event_type parity_event;
    pec_pkg::pec_event_type far_end_event;

    function automatic logic is_counter_addr(input logic [7:0] a);
        is_counter_addr = a == pec_pkg::ADDR_PARITY_LOW
            || a == pec_pkg::ADDR_PARITY_HIGH
            || a == pec_pkg::ADDR_FAR_END_LOW
            || a == pec_pkg::ADDR_FAR_END_HIGH;
    endfunction : is_counter_addr

    // two-stage pin synchroniser, third stage for edge detect
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bus_s1_q <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                          addr: 8'h00, data: 8'h00};
            bus_s2_q <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                          addr: 8'h00, data: 8'h00};
            bus_s3_q <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                          addr: 8'h00, data: 8'h00};
        end else begin
            bus_s1_q <= '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n,
                          addr: addr, data: data_in};
            bus_s2_q <= bus_s1_q;
            bus_s3_q <= bus_s2_q;
        end
    end

    // write completes on trailing edge of the strobe
    assign write_done = bus_s2_q.wr_n && !bus_s3_q.wr_n && !bus_s3_q.cs_n;
    assign path_poll = write_done && (is_counter_addr(bus_s3_q.addr)
        || bus_s3_q.addr == pec_pkg::ADDR_MASTER);

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            poll_all_q <= 1'b0;
        end else begin
            poll_all_q <= write_done
                && bus_s3_q.addr == pec_pkg::ADDR_MASTER;
        end
    end
    assign poll_all = poll_all_q;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            control_q <= pec_pkg::ACCUM_CONTROL_RESET;
        end else if (write_done
                     && bus_s3_q.addr == pec_pkg::ADDR_ACCUM_CONTROL) begin
            control_q <= bus_s3_q.data & pec_pkg::ACCUM_CONTROL_MASK;
        end
    end

    // event shaping per payload envelope
    always_comb begin
        parity_clip = parity_bits > pec_pkg::MAX_PARITY_BITS
            ? pec_pkg::MAX_PARITY_BITS : parity_bits;
        parity_event.valid = spe_done;
        if (control_q[pec_pkg::BLOCK_MODE_BIT]) begin
            parity_event.amount = {3'h0, parity_bits != 4'h0};
        end else begin
            parity_event.amount = parity_clip;
        end
        far_end_event.valid = g1_done;
        far_end_event.amount = far_end_value;
    end

    pec_accum u_parity (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .event_in(parity_event),
        .poll(path_poll),
        .hold_q(parity_hold)
    );

    pec_accum u_far_end (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .event_in(far_end_event),
        .poll(path_poll),
        .hold_q(far_end_hold)
    );

    // registered read data while strobe held
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            data_out_q <= 8'h00;
            data_oe_q <= 1'b0;
        end else begin
            data_oe_q <= !bus_s2_q.cs_n && !bus_s2_q.rd_n;
            case (bus_s2_q.addr)
                pec_pkg::ADDR_PARITY_LOW: begin
                    data_out_q <= parity_hold[7:0];
                end
                pec_pkg::ADDR_PARITY_HIGH: begin
                    data_out_q <= parity_hold[15:8];
                end
                pec_pkg::ADDR_FAR_END_LOW: begin
                    data_out_q <= far_end_hold[7:0];
                end
                pec_pkg::ADDR_FAR_END_HIGH: begin
                    data_out_q <= far_end_hold[15:8];
                end
                pec_pkg::ADDR_ACCUM_CONTROL: begin
                    data_out_q <= control_q;
                end
                default: begin
                    data_out_q <= pec_pkg::READ_UNMAPPED;
                end
            endcase
        end
    end
    assign data_out = data_out_q;
    assign data_oe = data_oe_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    a_block_mode_one: assert property (
        spe_done && control_q[5] |-> parity_event.amount <= 4'h1
            && (parity_event.amount == 4'h0) == (parity_bits == 4'h0))
        else $error("block mode added more than one");
    a_bit_mode_sum: assert property (
        spe_done && !control_q[5] && parity_bits <= 4'h8 |->
            parity_event.amount == parity_bits)
        else $error("bit mode amount differs from mismatched bits");
    a_control_reserved: assert property (
        (control_q & 8'hdf) == 8'h00)
        else $error("reserved control bits set");
    a_master_polls: assert property (
        write_done && bus_s3_q.addr == 8'h00 |-> path_poll ##1 poll_all)
        else $error("master write did not poll all counters");
    a_counter_write_polls: assert property (
        write_done && bus_s3_q.addr >= 8'h38 && bus_s3_q.addr <= 8'h3b
            |-> path_poll)
        else $error("counter write did not poll");
    a_read_parity_low: assert property (
        bus_s2_q.addr == 8'h38 |=> data_out == $past(parity_hold[7:0]))
        else $error("parity low byte read wrong");
    a_read_far_high: assert property (
        bus_s2_q.addr == 8'h3b |=> data_out == $past(far_end_hold[15:8]))
        else $error("far-end high byte read wrong");
    a_read_parity_high: assert property (
        bus_s2_q.addr == 8'h39 |=> data_out == $past(parity_hold[15:8]))
        else $error("parity high byte read wrong");
    a_read_far_low: assert property (
        bus_s2_q.addr == 8'h3a |=> data_out == $past(far_end_hold[7:0]))
        else $error("far-end low byte read wrong");
    a_read_control: assert property (
        bus_s2_q.addr == 8'h3d |=> (data_out & 8'hdf) == 8'h00)
        else $error("control read shows reserved bits");
    a_read_enable: assert property (
        !bus_s2_q.cs_n && !bus_s2_q.rd_n |=> data_oe)
        else $error("read strobe did not enable data");
    a_read_idle: assert property (
        bus_s2_q.cs_n || bus_s2_q.rd_n |=> !data_oe)
        else $error("data enabled without read strobe");
    a_poll_only_write: assert property (
        path_poll |-> write_done)
        else $error("poll without a completed write");
    a_control_write_quiet: assert property (
        write_done && bus_s3_q.addr == 8'h3d |-> !path_poll)
        else $error("control write polled the counters");
    a_poll_all_pulse: assert property (
        poll_all |=> !poll_all)
        else $error("master poll strobe longer than one cycle");
    a_poll_all_cause: assert property (
        poll_all |-> $past(write_done))
        else $error("master poll strobe without a write");
    a_bit_mode_clips: assert property (
        spe_done && !control_q[5] && parity_bits > 4'h8 |->
            parity_event.amount == 4'h8)
        else $error("bit mode amount above eight");
    a_control_write_masks: assert property (
        write_done && bus_s3_q.addr == 8'h3d |=>
            control_q == ($past(bus_s3_q.data) & 8'h20))
        else $error("control write not stored as masked");
    c_master_poll: cover property (poll_all);
    c_block_mode_event: cover property (spe_done && control_q[5]);
    c_counter_read: cover property (data_oe && bus_s2_q.addr == 8'h39);
endmodule : pec_path_error_counters

// >>> pec_path_error_counters_tb.sv
// self-checking testbench for the path error counters
`timescale 1ns/1ns
module pec_path_error_counters_tb;
    logic clk_sys, reset_n, cs_n, rd_n, wr_n, spe_done, g1_done;
    logic [7:0] addr, data_in, data_out, p1, p2, f1, f2, got;
    logic [3:0] parity_bits, far_end_value;
    logic data_oe, poll_all;
    logic [7:0] poll_addr [5];
    int err_count, num_checks, poll_seen;

    pec_path_error_counters DUT (
        .clk_sys(clk_sys), .reset_n(reset_n), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .spe_done(spe_done), .parity_bits(parity_bits),
        .g1_done(g1_done), .far_end_value(far_end_value),
        .poll_all(poll_all));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    always @(negedge clk_sys) begin
        if (poll_all === 1'b1) poll_seen++;
    end

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk8

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        cs_n = 1'b0;
        wr_n = 1'b0;
        addr = a;
        data_in = d;
        repeat (4) @(negedge clk_sys);
        wr_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        cs_n = 1'b1;
        repeat (3) @(negedge clk_sys);
    endtask : wr

    task automatic rdv(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        cs_n = 1'b0;
        rd_n = 1'b0;
        addr = a;
        repeat (5) @(negedge clk_sys);
        chk8({7'h00, data_oe}, 8'h01);
        d = data_out;
        rd_n = 1'b1;
        cs_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk8({7'h00, data_oe}, 8'h00);
    endtask : rdv

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rdv(a, d);
        chk8(d, e);
    endtask : rd

    task automatic ev(input logic s, input logic [3:0] p, input logic g,
            input logic [3:0] f);
        @(negedge clk_sys);
        spe_done = s;
        parity_bits = p;
        g1_done = g;
        far_end_value = f;
        @(negedge clk_sys);
        spe_done = 1'b0;
        g1_done = 1'b0;
    endtask : ev

    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        test_done();
    end

    initial begin
        {cs_n, rd_n, wr_n} = 3'b111;
        {spe_done, g1_done} = 2'b00;
        addr = 8'h00;
        data_in = 8'h00;
        parity_bits = 4'h0;
        far_end_value = 4'h0;
        reset_n = 1'b0;
        poll_addr = '{8'h38, 8'h39, 8'h3a, 8'h3b, 8'h00};
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys) reset_n = 1'b1;
        rd(pec_pkg::ADDR_ACCUM_CONTROL, 8'h00);
        rd(pec_pkg::ADDR_PARITY_LOW, 8'h00);
        rd(8'h3c, pec_pkg::READ_UNMAPPED);
        // bit mode, every poll address, fresh period each time
        for (int i = 0; i < 5; i++) begin
            ev(1'b1, 4'(i + 5), 1'b1, 4'(i + 11));
            ev(1'b1, 4'h8, 1'b0, 4'h0);
            wr(poll_addr[i], 8'hff);
            rd(8'h38, 8'((i + 5 > 8 ? 8 : i + 5) + 8));
            rd(8'h39, 8'h00);
            rd(8'h3a, 8'(i + 11));
            rd(8'h3b, 8'h00);
        end
        chk8(8'(poll_seen), 8'h01);
        wr(pec_pkg::ADDR_ACCUM_CONTROL, 8'hff);
        rd(pec_pkg::ADDR_ACCUM_CONTROL, 8'h20);
        ev(1'b1, 4'h3, 1'b0, 4'h0);
        ev(1'b1, 4'h0, 1'b0, 4'h0);
        ev(1'b1, 4'h8, 1'b0, 4'h0);
        wr(8'h39, 8'h00);
        rd(8'h38, 8'h02);
        // events every cycle straddling a poll
        @(negedge clk_sys);
        {spe_done, g1_done} = 2'b11;
        parity_bits = 4'h1;
        far_end_value = 4'h1;
        wr(8'h3a, 8'h00);
        {spe_done, g1_done} = 2'b00;
        rdv(8'h38, p1);
        rdv(8'h3a, f1);
        wr(8'h38, 8'h00);
        rdv(8'h38, p2);
        rdv(8'h3a, f2);
        chk8(p1 + p2, 8'h0c);
        chk8(f1 + f2, 8'h0c);
        // long run past full scale
        @(negedge clk_sys);
        g1_done = 1'b1;
        far_end_value = 4'hf;
        repeat (4400) @(negedge clk_sys);
        g1_done = 1'b0;
        wr(8'h3b, 8'h00);
        rd(8'h3a, 8'hff);
        rd(8'h3b, 8'hff);
        // new events must not disturb the holding register
        ev(1'b0, 4'h0, 1'b1, 4'h5);
        rdv(8'h3b, got);
        chk8(got, 8'hff);
        // accumulator restarted from zero after the poll
        wr(8'h3a, 8'h00);
        rd(8'h3a, 8'h05);
        test_done();
    end
endmodule : pec_path_error_counters_tb
